// ---- design/ufic_core.sv ----
// serial port frame configuration, pin routing, parity, idle detect and irq gating
// assumes flags, bit ticks and characters come from transmitter/receiver logic on clk
//
// Functional notes
// - loop select 1 feeds transmitter output to receiver; 0 uses separate pins.
// - stop-in-wait 0 keeps port clocks running in wait; 1 freezes them.
// - single-wire select is ignored whenever loop select is 0.
// - loop set: 0 gives internal loop-back, 1 gives single wire on transmit pin.
// - length select 0 gives 8 data bits; 1 adds a ninth before stop.
// - wakeup method bit 0 idle-line, 1 address-mark.
// - idle needs 10 or 11 high bit times, counted after start or stop.
// - parity on generates and checks parity in the character msb.
// - parity type 0 even, 1 odd, counting all ones including parity bit.
// - transmit empty enable gates an interrupt from the transmit empty flag.
// - transmit done enable gates an interrupt from the transmit done flag.
// - receive full enable gates an interrupt from the receive full flag.
// - idle enable gates an interrupt from the idle flag.
// - interrupt enable register is readable and writable at any time.
// - frame config register is read/write, all bits reset to zero.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module ufic_core
    import ufic_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic tx_empty_flag,
    input wire logic tx_done_flag,
    input wire logic rx_full_flag,
    input wire logic cpu_wait,
    input wire logic tx_serial,
    input wire logic tx_dir,
    input wire logic rxd_pin_in,
    input wire logic txd_pin_in,
    output logic txd_pin_out,
    output logic txd_pin_oe,
    output logic rx_serial,
    input wire logic bit_tick,
    input wire logic rx_stop_seen,
    input wire logic [8:0] tx_char_in,
    output logic [8:0] tx_char_out,
    input wire logic [8:0] rx_char_in,
    input wire logic rx_char_valid,
    output logic rx_parity_err,
    output logic port_clk_run,
    output logic nine_bit_mode,
    output logic wake_addr_mark,
    output logic idle_flag,
    output logic irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // xor of the data bits below the parity position
    function automatic logic data_xor(input logic [8:0] c, input logic nine);
        return nine ? ^c[7:0] : ^c[6:0];
    endfunction : data_xor

    function automatic logic [8:0] with_parity(input logic [8:0] c, input ufic_frame_cfg_s f);
        logic [8:0] r;
        r = f.nine_bit ? c : {1'b0, c[7:0]};
        if (f.parity_on) begin
            if (f.nine_bit) begin
                r[8] = data_xor(c, 1'b1) ^ f.parity_odd_select;
            end else begin
                r[7] = data_xor(c, 1'b0) ^ f.parity_odd_select;
            end
        end
        return r;
    endfunction : with_parity

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    ufic_frame_cfg_s frame_cfg_q;
    logic [7:0] irq_en_q;
    logic [7:0] evt_status_q;
    logic [7:0] evt_mask_q;
    logic [7:0] rdata_q;
    logic [7:0] evt_set;
    logic [7:0] rdata_d;
    ufic_flags_s flags_prev_q;
    ufic_flags_s flags_now;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_cfg_q <= ufic_frame_cfg_s'(FRAME_CFG_RST);
        end else if (wr && addr == ADDR_FRAME_CFG) begin
            frame_cfg_q <= ufic_frame_cfg_s'(wdata);
        end
    end

    // no gating on port state: software may rewrite enables mid-frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_en_q <= IRQ_EN_RST;
        end else if (wr && addr == ADDR_IRQ_EN) begin
            irq_en_q <= wdata & IRQ_EN_WMASK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_mask_q <= EVT_MASK_RST;
        end else if (wr && addr == ADDR_EVT_MASK) begin
            evt_mask_q <= wdata & EVT_WMASK;
        end
    end

    // sticky events; a new event wins over the clear-on-read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_status_q <= EVT_STATUS_RST;
        end else if (rd && addr == ADDR_EVT_STATUS) begin
            evt_status_q <= evt_set;
        end else begin
            evt_status_q <= evt_status_q | evt_set;
        end
    end

    always_comb begin
        unique case (addr)
            ADDR_FRAME_CFG: rdata_d = frame_cfg_q;
            ADDR_IRQ_EN: rdata_d = irq_en_q;
            ADDR_EVT_STATUS: rdata_d = evt_status_q;
            ADDR_EVT_MASK: rdata_d = evt_mask_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd ? rdata_d : 8'h00;
        end
    end
    assign rdata = rdata_q;

    // ------------------------------------------------------------
    // pin synchronisers and routing
    // ------------------------------------------------------------
    logic rxd_s1_q, rxd_s2_q, txd_s1_q, txd_s2_q;
    logic rx_serial_q, txd_out_q, txd_oe_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            txd_s1_q <= 1'b1;
            txd_s2_q <= 1'b1;
        end else begin
            rxd_s1_q <= rxd_pin_in;
            rxd_s2_q <= rxd_s1_q;
            txd_s1_q <= txd_pin_in;
            txd_s2_q <= txd_s1_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_serial_q <= 1'b1;
            txd_out_q <= 1'b1;
            txd_oe_q <= 1'b0;
        end else begin
            txd_out_q <= tx_serial;
            if (!frame_cfg_q.loop_select) begin
                rx_serial_q <= rxd_s2_q;
                txd_oe_q <= 1'b1;
            end else if (!frame_cfg_q.single_wire_select) begin
                rx_serial_q <= tx_serial;
                txd_oe_q <= 1'b1;
            end else begin
                // single wire: receiver hears the shared pin, direction set outside
                rx_serial_q <= txd_s2_q;
                txd_oe_q <= tx_dir;
            end
        end
    end
    assign rx_serial = rx_serial_q;
    assign txd_pin_out = txd_out_q;
    assign txd_pin_oe = txd_oe_q;

    // ------------------------------------------------------------
    // wait mode, format and wakeup controls
    // ------------------------------------------------------------
    logic clk_run_q, nine_q, wake_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_run_q <= 1'b1;
            nine_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            clk_run_q <= !(cpu_wait && frame_cfg_q.stop_in_wait);
            nine_q <= frame_cfg_q.nine_bit;
            wake_q <= frame_cfg_q.wake_addr_mark;
        end
    end
    assign port_clk_run = clk_run_q;
    assign nine_bit_mode = nine_q;
    assign wake_addr_mark = wake_q;

    // ------------------------------------------------------------
    // parity generation and check
    // ------------------------------------------------------------
    logic [8:0] tx_char_q;
    logic par_err_q, par_err_prev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_char_q <= 9'h000;
        end else begin
            tx_char_q <= with_parity(tx_char_in, frame_cfg_q);
        end
    end
    assign tx_char_out = tx_char_q;

    // check holds until the next character arrives
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            par_err_q <= 1'b0;
        end else if (rx_char_valid) begin
            par_err_q <= frame_cfg_q.parity_on &&
                ((data_xor(rx_char_in, frame_cfg_q.nine_bit) ^
                  (frame_cfg_q.nine_bit ? rx_char_in[8] : rx_char_in[7]))
                 != frame_cfg_q.parity_odd_select);
        end
    end
    assign rx_parity_err = par_err_q;

    // ------------------------------------------------------------
    // idle line detector
    // ------------------------------------------------------------
    ufic_idle_e idle_st_q;
    logic [3:0] idle_cnt_q;
    logic [3:0] idle_target;
    logic idle_flag_q;
    logic idle_hit;

    assign idle_target = frame_cfg_q.nine_bit ? IDLE_BITS_LONG : IDLE_BITS_SHORT;
    assign idle_hit = idle_st_q == IDLE_COUNT && bit_tick && rx_serial_q &&
        idle_cnt_q == idle_target - 4'h1;

    // a low level restarts the count; after-stop mode waits for the stop bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idle_st_q <= IDLE_ARM;
            idle_cnt_q <= 4'h0;
        end else begin
            unique case (idle_st_q)
                IDLE_ARM: begin
                    idle_cnt_q <= 4'h0;
                    if (frame_cfg_q.idle_count_after_stop) begin
                        if (rx_stop_seen) begin
                            idle_st_q <= IDLE_COUNT;
                        end
                    end else if (rx_serial_q) begin
                        idle_st_q <= IDLE_COUNT;
                    end
                end
                IDLE_COUNT: begin
                    if (!rx_serial_q) begin
                        idle_st_q <= IDLE_ARM;
                    end else if (idle_hit) begin
                        idle_st_q <= IDLE_DONE;
                    end else if (bit_tick) begin
                        idle_cnt_q <= idle_cnt_q + 4'h1;
                    end
                end
                IDLE_DONE: begin
                    if (!rx_serial_q) begin
                        idle_st_q <= IDLE_ARM;
                    end
                end
                default: idle_st_q <= IDLE_ARM;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idle_flag_q <= 1'b0;
        end else if (idle_hit) begin
            idle_flag_q <= 1'b1;
        end else if (!rx_serial_q) begin
            idle_flag_q <= 1'b0;
        end
    end
    assign idle_flag = idle_flag_q;

    // ------------------------------------------------------------
    // interrupt gating
    // ------------------------------------------------------------
    logic irq_q;
    logic flag_req;

    assign flags_now = '{tx_empty_flag, tx_done_flag, rx_full_flag, idle_flag_q};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {flags_prev_q, par_err_prev_q} <= '0;
        end else begin
            {flags_prev_q, par_err_prev_q} <= {flags_now, par_err_q};
        end
    end

    always_comb begin
        evt_set = 8'h00;
        evt_set[BIT_TX_EMPTY:BIT_IDLE] = flags_now & ~flags_prev_q;
        evt_set[BIT_PAR_ERR] = par_err_q && !par_err_prev_q;
    end

    assign flag_req = (tx_empty_flag && irq_en_q[BIT_TX_EMPTY]) ||
        (tx_done_flag && irq_en_q[BIT_TX_DONE]) ||
        (rx_full_flag && irq_en_q[BIT_RX_FULL]) ||
        (idle_flag_q && irq_en_q[BIT_IDLE]);

    // registered so the request line never glitches on flag edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_req || |(evt_status_q & evt_mask_q);
        end
    end
    assign irq = irq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_cfg_wr;
        wr && addr == ADDR_FRAME_CFG;
    endsequence
    sequence s_cfg_rd;
        rd && addr == ADDR_FRAME_CFG && !wr;
    endsequence

    property p_normal_route;
        !frame_cfg_q.loop_select |=> rx_serial == $past(rxd_s2_q) && txd_pin_oe;
    endproperty
    a_normal_route: assert property (p_normal_route) else $error("normal routing wrong");

    property p_loop_internal;
        frame_cfg_q.loop_select && !frame_cfg_q.single_wire_select
            |=> rx_serial == $past(tx_serial);
    endproperty
    a_loop_internal: assert property (p_loop_internal) else $error("loop-back wrong");

    property p_single_wire;
        frame_cfg_q.loop_select && frame_cfg_q.single_wire_select
            |=> rx_serial == $past(txd_s2_q) && txd_pin_oe == $past(tx_dir);
    endproperty
    a_single_wire: assert property (p_single_wire) else $error("single wire wrong");

    property p_wait_freeze;
        cpu_wait && frame_cfg_q.stop_in_wait |=> !port_clk_run;
    endproperty
    a_wait_freeze: assert property (p_wait_freeze) else $error("clocks not frozen");

    property p_eight_bit;
        !frame_cfg_q.nine_bit |=> tx_char_out[8] == 1'b0;
    endproperty
    a_eight_bit: assert property (p_eight_bit) else $error("ninth bit in 8-bit mode");

    property p_tx_parity;
        frame_cfg_q.parity_on && !frame_cfg_q.nine_bit && $stable(frame_cfg_q)
            |=> ^tx_char_out[7:0] == $past(frame_cfg_q.parity_odd_select);
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("tx parity wrong");

    property p_idle_count;
        $rose(idle_flag) |-> $past(idle_cnt_q) == $past(idle_target) - 4'h1 && $past(rx_serial_q);
    endproperty
    a_idle_count: assert property (p_idle_count) else $error("idle too early");

    property p_rx_irq;
        rx_full_flag && irq_en_q[BIT_RX_FULL] |=> irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");

    property p_no_irq;
        !flag_req && (evt_status_q & evt_mask_q) == 8'h00 |=> !irq;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("spurious irq");

    property p_cfg_readback;
        s_cfg_wr ##1 s_cfg_rd |=> rdata == $past(wdata, 2);
    endproperty
    a_cfg_readback: assert property (p_cfg_readback) else $error("cfg readback wrong");

endmodule : ufic_core

// ---- design/ufic_pkg.sv ----
// constants, register layout and carriers of the serial port frame and irq config block
// assumes a byte-wide register port with addresses of ADDR_W bits
package ufic_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_FRAME_CFG = 3'h0;
    localparam logic [2:0] ADDR_IRQ_EN = 3'h1;
    localparam logic [2:0] ADDR_EVT_STATUS = 3'h2;
    localparam logic [2:0] ADDR_EVT_MASK = 3'h3;

    localparam logic [7:0] FRAME_CFG_RST = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] EVT_STATUS_RST = 8'h00;
    localparam logic [7:0] EVT_MASK_RST = 8'h00;

    // ------------------------------------------------------------
    // field positions of irq enable, event status and event mask
    // ------------------------------------------------------------
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_TX_DONE = 6;
    localparam int BIT_RX_FULL = 5;
    localparam int BIT_IDLE = 4;
    localparam int BIT_PAR_ERR = 3;
    localparam logic [7:0] IRQ_EN_WMASK = 8'hf0;
    localparam logic [7:0] EVT_WMASK = 8'hf8;

    // ------------------------------------------------------------
    // idle line bit counts
    // ------------------------------------------------------------
    localparam logic [3:0] IDLE_BITS_SHORT = 4'ha;
    localparam logic [3:0] IDLE_BITS_LONG = 4'hb;

    typedef struct packed {
        logic loop_select;
        logic stop_in_wait;
        logic single_wire_select;
        logic nine_bit;
        logic wake_addr_mark;
        logic idle_count_after_stop;
        logic parity_on;
        logic parity_odd_select;
    } ufic_frame_cfg_s;

    typedef struct packed {
        logic tx_empty_flag;
        logic tx_done_flag;
        logic rx_full_flag;
        logic idle_flag;
    } ufic_flags_s;

    typedef enum logic [2:0] {
        IDLE_ARM = 3'b001,
        IDLE_COUNT = 3'b010,
        IDLE_DONE = 3'b100
    } ufic_idle_e;

endpackage : ufic_pkg

// ---- testbench/ufic_remote.sv ----
// remote serial transceiver model on the rxd and txd lines
// assumes the bench shares clk and resolves the txd wire from the enables
`timescale 1ns/1ps
module ufic_remote #(
    parameter int BIT_CYC = 8
) (
    input wire logic clk,
    output logic rxd_line,
    output logic txd_drive
);
    // ----------------------------------------
    // lines idle high, as the pull-up leaves them
    // ----------------------------------------
    initial begin
        rxd_line = 1'b1;
        txd_drive = 1'b1;
    end

    task automatic send(input logic [8:0] d, input logic nine);
        rxd_line <= 1'b0;
        repeat (BIT_CYC) @(posedge clk);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            rxd_line <= d[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        rxd_line <= 1'b1;
        repeat (BIT_CYC) @(posedge clk);
    endtask : send

    task automatic set_lines(input logic r, input logic t);
        rxd_line <= r;
        txd_drive <= t;
    endtask : set_lines
endmodule : ufic_remote

// ---- testbench/tb_uart_frame_and_irq_config.sv ----
// self-checking bench of ufic_core: registers, routing, idle, irq, parity
// assumes the remote model on the serial lines and a 200 MHz clock
`timescale 1ns/1ps
module tb_uart_frame_and_irq_config import ufic_pkg::*;;
    logic clk, rstn, wr, rd, cpu_wait, tx_serial, tx_dir, bit_tick, rx_stop_seen, rx_char_valid;
    logic tx_empty_flag, tx_done_flag, rx_full_flag, rxd_line, txd_drive, txd_wire;
    logic txd_pin_out, txd_pin_oe, rx_serial, rx_parity_err, port_clk_run, nine_bit_mode;
    logic wake_addr_mark, idle_flag, irq;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata;
    logic [8:0] tx_char_in, tx_char_out, rx_char_in;
    int bad_count, samples_checked, cycles;

    // released txd falls back to the remote side's level
    assign txd_wire = txd_pin_oe ? txd_pin_out : txd_drive;

    ufic_remote ufic_remote_i (.clk(clk), .rxd_line(rxd_line), .txd_drive(txd_drive));
    ufic_core ufic_core_i (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .tx_empty_flag(tx_empty_flag), .tx_done_flag(tx_done_flag),
        .rx_full_flag(rx_full_flag), .cpu_wait(cpu_wait), .tx_serial(tx_serial),
        .tx_dir(tx_dir), .rxd_pin_in(rxd_line), .txd_pin_in(txd_wire),
        .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe), .rx_serial(rx_serial),
        .bit_tick(bit_tick), .rx_stop_seen(rx_stop_seen), .tx_char_in(tx_char_in),
        .tx_char_out(tx_char_out), .rx_char_in(rx_char_in), .rx_char_valid(rx_char_valid),
        .rx_parity_err(rx_parity_err), .port_clk_run(port_clk_run),
        .nine_bit_mode(nine_bit_mode), .wake_addr_mark(wake_addr_mark),
        .idle_flag(idle_flag), .irq(irq)
    );

    // ----------------------------------------
    // clock, timeout, report
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_val(input logic [10:0] got, input logic [10:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_val({10'h0, got}, {10'h0, exp}, what);
    endtask : chk_bit

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        chk_val({3'h0, got}, {3'h0, exp}, what);
    endtask : chk_reg

    // ----------------------------------------
    // bus and stimulus helpers
    // ----------------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        logic [7:0] got;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        got = rdata;
        @(posedge clk);
        chk_reg(got, exp, what);
    endtask : reg_rd

    task automatic tick(input int n);
        repeat (n) begin
            bit_tick <= 1'b1;
            @(posedge clk);
            bit_tick <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : tick

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_regs;
        reg_rd(ADDR_FRAME_CFG, FRAME_CFG_RST, "cfg reset");
        reg_rd(ADDR_IRQ_EN, IRQ_EN_RST, "en reset");
        reg_wr(ADDR_FRAME_CFG, 8'h5a);
        reg_rd(ADDR_FRAME_CFG, 8'h5a, "cfg rw");
        addr <= ADDR_FRAME_CFG;
        wdata <= 8'h24;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_reg(rdata, 8'h24, "back to back");
        @(posedge clk);
        reg_wr(ADDR_IRQ_EN, 8'hff);
        reg_rd(ADDR_IRQ_EN, 8'hf0, "en rw");
        reg_wr(3'h5, 8'hff);
        reg_rd(3'h5, 8'h00, "unmapped");
        reg_wr(ADDR_IRQ_EN, 8'h00);
    endtask : test_regs

    task automatic test_cfg;
        cpu_wait <= 1'b1;
        reg_wr(ADDR_FRAME_CFG, 8'h00);
        wait_cyc(1);
        chk_bit(port_clk_run, 1'b1, "run in wait");
        chk_bit(nine_bit_mode, 1'b0, "8 bit");
        chk_bit(wake_addr_mark, 1'b0, "idle wake");
        @(posedge clk);
        reg_wr(ADDR_FRAME_CFG, 8'h58);
        wait_cyc(1);
        chk_bit(port_clk_run, 1'b0, "frozen");
        chk_bit(nine_bit_mode, 1'b1, "9 bit");
        chk_bit(wake_addr_mark, 1'b1, "mark wake");
        @(posedge clk);
        cpu_wait <= 1'b0;
        wait_cyc(2);
        chk_bit(port_clk_run, 1'b1, "run");
        @(posedge clk);
    endtask : test_cfg

    // drv = {tx_serial, rxd pin, tx_dir, remote txd}
    task automatic route(input logic [7:0] cfg, input logic [3:0] drv, input logic erx,
                         input logic eoe);
        reg_wr(ADDR_FRAME_CFG, cfg);
        tx_serial <= drv[3];
        tx_dir <= drv[1];
        ufic_remote_i.set_lines(drv[2], drv[0]);
        wait_cyc(5);
        chk_bit(rx_serial, erx, "rx route");
        chk_bit(txd_pin_oe, eoe, "txd enable");
        chk_bit(txd_pin_out, drv[3], "txd out");
        @(posedge clk);
    endtask : route

    task automatic idle_run(input logic [7:0] cfg, input int pre, input int need);
        logic [10:0] got;
        reg_wr(ADDR_FRAME_CFG, cfg);
        reg_wr(ADDR_IRQ_EN, 8'h10);
        fork
            ufic_remote_i.send(9'h1a5, cfg[4]);
            for (int i = 0; i < 11; i++) begin
                repeat (i == 0 ? 7 : 8) @(posedge clk);
                #1;
                got[i] = rx_serial;
            end
        join
        chk_val(got, cfg[4] ? {1'b1, 9'h1a5, 1'b0} : {2'b11, 8'ha5, 1'b0}, "frame");
        @(posedge clk);
        tick(pre);
        rx_stop_seen <= 1'b1;
        @(posedge clk);
        rx_stop_seen <= 1'b0;
        tick(need - 1);
        wait_cyc(0);
        chk_bit(idle_flag, 1'b0, "idle early");
        chk_bit(irq, 1'b0, "irq early");
        @(posedge clk);
        tick(1);
        wait_cyc(0);
        chk_bit(idle_flag, 1'b1, "idle");
        chk_bit(irq, 1'b1, "idle irq");
        @(posedge clk);
    endtask : idle_run

    task automatic irq_one(input logic [2:0] fl, input logic [7:0] en, input logic exp);
        {tx_empty_flag, tx_done_flag, rx_full_flag} <= fl;
        reg_wr(ADDR_IRQ_EN, en);
        wait_cyc(1);
        chk_bit(irq, exp, "irq");
        @(posedge clk);
    endtask : irq_one

    task automatic test_mask;
        reg_rd(ADDR_EVT_STATUS, 8'hf0, "events");
        reg_rd(ADDR_EVT_STATUS, 8'h00, "read clears");
        reg_wr(ADDR_EVT_MASK, 8'h20);
        rx_full_flag <= 1'b1;
        @(posedge clk);
        rx_full_flag <= 1'b0;
        wait_cyc(3);
        chk_bit(irq, 1'b1, "sticky irq");
        @(posedge clk);
        reg_rd(ADDR_EVT_STATUS, 8'h20, "rx event");
        wait_cyc(1);
        chk_bit(irq, 1'b0, "irq cleared");
        @(posedge clk);
        reg_wr(ADDR_EVT_MASK, 8'h00);
    endtask : test_mask

    task automatic par(input logic [7:0] cfg, input logic [8:0] ch, input logic [8:0] etx,
                       input logic eerr);
        reg_wr(ADDR_FRAME_CFG, cfg);
        tx_char_in <= ch;
        rx_char_in <= ch;
        rx_char_valid <= 1'b1;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        wait_cyc(1);
        chk_val({2'b00, tx_char_out}, {2'b00, etx}, "tx parity");
        chk_bit(rx_parity_err, eerr, "rx parity");
        @(posedge clk);
    endtask : par

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        {wr, rd, cpu_wait, tx_dir, bit_tick, rx_stop_seen, rx_char_valid} = 7'h00;
        {tx_empty_flag, tx_done_flag, rx_full_flag} = 3'h0;
        tx_serial = 1'b1;
        addr = '0;
        wdata = 8'h00;
        tx_char_in = 9'h000;
        rx_char_in = 9'h000;
        bad_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        test_regs();
        test_cfg();
        route(8'h00, 4'b1000, 1'b0, 1'b1);
        route(8'h00, 4'b0100, 1'b1, 1'b1);
        route(8'h20, 4'b1000, 1'b0, 1'b1);
        route(8'h80, 4'b1000, 1'b1, 1'b1);
        route(8'h80, 4'b0100, 1'b0, 1'b1);
        route(8'ha0, 4'b0011, 1'b0, 1'b1);
        route(8'ha0, 4'b0101, 1'b1, 1'b0);
        idle_run(8'h00, 4, 6);
        idle_run(8'h10, 4, 7);
        idle_run(8'h04, 4, 10);
        irq_one(3'b100, 8'h80, 1'b1);
        irq_one(3'b100, 8'h60, 1'b0);
        irq_one(3'b010, 8'h40, 1'b1);
        irq_one(3'b010, 8'ha0, 1'b0);
        irq_one(3'b001, 8'h20, 1'b1);
        irq_one(3'b001, 8'hc0, 1'b0);
        irq_one(3'b110, 8'h40, 1'b1);
        irq_one(3'b000, 8'he0, 1'b0);
        test_mask();
        par(8'h02, 9'h003, 9'h003, 1'b0);
        par(8'h02, 9'h083, 9'h003, 1'b1);
        par(8'h03, 9'h083, 9'h083, 1'b0);
        par(8'h12, 9'h103, 9'h003, 1'b1);
        par(8'h12, 9'h001, 9'h101, 1'b1);
        par(8'h13, 9'h001, 9'h001, 1'b0);
        par(8'h00, 9'h183, 9'h083, 1'b0);
        give_verdict();
    end
endmodule : tb_uart_frame_and_irq_config
